// ===== common/nfc_params.svh
// Constants of the nibble to five-bit symbol codec.
// Assumes inclusion by the package and by the design files.
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH

// Data symbols, nibble n at bits [5n+4:5n]
`define NFC_ENC_TABLE 80'hef37a_bda72_7b96a_ad13e
`define NFC_SYM_W 5
`define NFC_NIB_W 4
`define NFC_NIB_CNT 16
`define NFC_SYM_IDLE 5'h1f
`define NFC_SYM_SSD1 5'h18
`define NFC_SYM_SSD2 5'h11
`define NFC_SYM_ESD1 5'h0d
`define NFC_SYM_ESD2 5'h07
`define NFC_SYM_TXERR 5'h04
`define NFC_NIB_PRE 4'h5
`define NFC_NIB_ZERO 4'h0
`define NFC_BUF_DEPTH 2

`endif

// ===== common/nfc_pkg.sv
// Types shared by the codec and its testbench.
// Assumes nfc_params.svh on the include path.
`include "nfc_params.svh"
package nfc_pkg;
   typedef enum logic [2:0] {
      CLS_DATA, CLS_IDLE, CLS_SSD1, CLS_SSD2, CLS_ESD1, CLS_ESD2, CLS_TXERR, CLS_INVALID
   } nfc_cls_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SSD2, TX_DATA, TX_ESD2} nfc_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_GOT_J, RX_FRAME, RX_GOT_T} nfc_rx_st_t;
   typedef struct packed {
      logic en;
      logic er;
      logic [`NFC_NIB_W-1:0] nib;
   } nfc_tx_nib_t;
   typedef struct packed {
      logic dv;
      logic er;
      logic sof;
      logic eof;
      logic [`NFC_NIB_W-1:0] nib;
   } nfc_rx_nib_t;
   typedef struct packed {
      nfc_cls_t cls;
      logic [`NFC_NIB_W-1:0] nib;
   } nfc_dec_t;
   typedef struct packed {
      nfc_tx_st_t tx_st;
      nfc_rx_st_t rx_st;
      nfc_rx_nib_t rx_out;
      nfc_cls_t rx_cls;
   } nfc_state_t;
endpackage

// ===== hw/nfc_codec.sv
// Nibble to five-bit symbol codec, transmit and receive paths.
// Assumes MAC nibbles and line symbols on the same 25 MHz clock.
// Contract
// - Encode all nibbles and controls; decode inverse
// - Fixed sixteen-entry data table, exact inverse
// - First frame nibble becomes 11000, recognised
// - Second nibble becomes 10001; pair means start
// - Append 01101 then 00111; recognised as end
// - Idle 11111 between frames; error 00100
// - Never emit undefined; decode them as invalid
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_codec (
   input wire logic clock,                       // 25 MHz clock
   input wire logic rst,                         // Async reset, high
   input wire nfc_pkg::nfc_tx_nib_t tx_in,       // MAC transmit nibble
   output logic tx_ready,                        // Nibble taken this cycle
   output logic [`NFC_SYM_W-1:0] sym_out,        // Line transmit symbol
   output logic sym_valid,                       // Symbol available
   input wire logic sym_ready,                   // Line takes symbol
   input wire logic [`NFC_SYM_W-1:0] rx_sym,     // Line receive symbol
   input wire logic rx_sym_valid,                // Receive symbol present
   output nfc_pkg::nfc_rx_nib_t rx_out,          // MAC receive nibble
   output nfc_pkg::nfc_cls_t rx_class            // Class of last symbol
);
   localparam logic [`NFC_NIB_CNT*`NFC_SYM_W-1:0] ENC = `NFC_ENC_TABLE;

   nfc_pkg::nfc_state_t s_q, s_d;
   logic [`NFC_SYM_W-1:0] enc_sym;
   logic buf_rdy;
   nfc_pkg::nfc_dec_t dec;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   function automatic logic [`NFC_SYM_W-1:0] enc_nib(input logic [`NFC_NIB_W-1:0] n);
      enc_nib = ENC[n*`NFC_SYM_W +: `NFC_SYM_W];
   endfunction

   function automatic nfc_pkg::nfc_dec_t dec_sym(input logic [`NFC_SYM_W-1:0] y);
      nfc_pkg::nfc_dec_t r;
      r.cls = nfc_pkg::CLS_INVALID;
      r.nib = `NFC_NIB_ZERO;
      for (int i = 0; i < `NFC_NIB_CNT; i++) begin
         if (ENC[i*`NFC_SYM_W +: `NFC_SYM_W] == y) begin
            r.cls = nfc_pkg::CLS_DATA;
            r.nib = `NFC_NIB_W'(i);
         end
      end
      unique case (y)
         `NFC_SYM_IDLE: r.cls = nfc_pkg::CLS_IDLE;
         `NFC_SYM_SSD1: r.cls = nfc_pkg::CLS_SSD1;
         `NFC_SYM_SSD2: r.cls = nfc_pkg::CLS_SSD2;
         `NFC_SYM_ESD1: r.cls = nfc_pkg::CLS_ESD1;
         `NFC_SYM_ESD2: r.cls = nfc_pkg::CLS_ESD2;
         `NFC_SYM_TXERR: r.cls = nfc_pkg::CLS_TXERR;
         default: r.cls = r.cls;
      endcase
      return r;
   endfunction

   // Symbols queue here so a line stall loses nothing
   nfc_fifo #(.W(`NFC_SYM_W), .DEPTH(`NFC_BUF_DEPTH)) u_buf (
      .clock(clock),
      .rst(rst),
      .in_valid(1'b1),
      .in_ready(buf_rdy),
      .in_data(enc_sym),
      .out_valid(sym_valid),
      .out_ready(sym_ready),
      .out_data(sym_out)
   );

   assign tx_ready = buf_rdy;
   assign dec = dec_sym(rx_sym);
   assign rx_out = s_q.rx_out;
   assign rx_class = s_q.rx_cls;

   always_comb begin
      s_d = s_q;
      enc_sym = `NFC_SYM_IDLE;
      // Transmit: one symbol per accepted cycle
      unique case (s_q.tx_st)
         nfc_pkg::TX_IDLE: begin
            if (tx_in.en) begin
               enc_sym = `NFC_SYM_SSD1;
               if (buf_rdy) s_d.tx_st = nfc_pkg::TX_SSD2;
            end
         end
         nfc_pkg::TX_SSD2: begin
            enc_sym = `NFC_SYM_SSD2;
            if (buf_rdy) s_d.tx_st = nfc_pkg::TX_DATA;
         end
         nfc_pkg::TX_DATA: begin
            if (!tx_in.en) begin
               enc_sym = `NFC_SYM_ESD1;
               if (buf_rdy) s_d.tx_st = nfc_pkg::TX_ESD2;
            end else if (tx_in.er) begin
               enc_sym = `NFC_SYM_TXERR;
            end else begin
               enc_sym = enc_nib(tx_in.nib);
            end
         end
         nfc_pkg::TX_ESD2: begin
            enc_sym = `NFC_SYM_ESD2;
            if (buf_rdy) s_d.tx_st = nfc_pkg::TX_IDLE;
         end
      endcase
      // Receive: rx_out stands one cycle; rx_class holds
      s_d.rx_out = '0;
      if (rx_sym_valid) begin
         s_d.rx_cls = dec.cls;
         unique case (s_q.rx_st)
            nfc_pkg::RX_IDLE: begin
               if (dec.cls == nfc_pkg::CLS_SSD1) s_d.rx_st = nfc_pkg::RX_GOT_J;
            end
            nfc_pkg::RX_GOT_J: begin
               if (dec.cls == nfc_pkg::CLS_SSD2) begin
                  s_d.rx_st = nfc_pkg::RX_FRAME;
                  s_d.rx_out.dv = 1'b1;
                  s_d.rx_out.sof = 1'b1;
                  s_d.rx_out.nib = `NFC_NIB_PRE;
               end else begin
                  s_d.rx_st = nfc_pkg::RX_IDLE;
               end
            end
            nfc_pkg::RX_FRAME: begin
               if (dec.cls == nfc_pkg::CLS_DATA) begin
                  s_d.rx_out.dv = 1'b1;
                  s_d.rx_out.nib = dec.nib;
               end else if (dec.cls == nfc_pkg::CLS_ESD1) begin
                  s_d.rx_st = nfc_pkg::RX_GOT_T;
               end else if (dec.cls == nfc_pkg::CLS_IDLE) begin
                  s_d.rx_out.er = 1'b1;
                  s_d.rx_st = nfc_pkg::RX_IDLE;
               end else begin
                  s_d.rx_out.dv = 1'b1;
                  s_d.rx_out.er = 1'b1;
               end
            end
            nfc_pkg::RX_GOT_T: begin
               s_d.rx_st = nfc_pkg::RX_IDLE;
               if (dec.cls == nfc_pkg::CLS_ESD2) begin
                  s_d.rx_out.eof = 1'b1;
               end else begin
                  s_d.rx_out.er = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '{tx_st: nfc_pkg::TX_IDLE, rx_st: nfc_pkg::RX_IDLE,
                  rx_out: '0, rx_cls: nfc_pkg::CLS_IDLE};
      end else begin
         s_q <= s_d;
      end
   end

   logic tx_step;
   nfc_pkg::nfc_dec_t enc_chk;
   assign tx_step = buf_rdy;
   // Encoder output run back through the decoder
   assign enc_chk = dec_sym(enc_sym);

   chk_tx_no_invalid: assert property (
      enc_chk.cls != nfc_pkg::CLS_INVALID)
      else $error("encoder produced an undefined symbol");
   chk_tx_data_map: assert property (
      tx_step && s_q.tx_st == nfc_pkg::TX_DATA && tx_in.en && !tx_in.er
      |-> enc_sym == enc_nib(tx_in.nib) && enc_chk.cls == nfc_pkg::CLS_DATA
      && enc_chk.nib == tx_in.nib)
      else $error("data nibble mapped to wrong symbol");
   chk_tx_start_pair: assert property (
      tx_step && s_q.tx_st == nfc_pkg::TX_IDLE && tx_in.en
      |-> enc_sym == `NFC_SYM_SSD1 ##1 enc_sym == `NFC_SYM_SSD2)
      else $error("frame start not sent as start pair");
   chk_tx_ssd2_next: assert property (
      tx_step && s_q.tx_st == nfc_pkg::TX_SSD2 |=> s_q.tx_st == nfc_pkg::TX_DATA)
      else $error("second start symbol not followed by data");
   chk_tx_end_pair: assert property (
      tx_step && s_q.tx_st == nfc_pkg::TX_DATA && !tx_in.en
      |-> enc_sym == `NFC_SYM_ESD1 ##1 enc_sym == `NFC_SYM_ESD2)
      else $error("frame end not sent as end pair");
   chk_tx_idle_fill: assert property (
      s_q.tx_st == nfc_pkg::TX_IDLE && !tx_in.en |-> enc_sym == `NFC_SYM_IDLE)
      else $error("idle symbol missing between frames");
   chk_rx_data_nib: assert property (
      rx_sym_valid && s_q.rx_st == nfc_pkg::RX_FRAME && dec.cls == nfc_pkg::CLS_DATA
      |=> rx_out.dv && !rx_out.er && rx_out.nib == $past(dec.nib))
      else $error("received data nibble wrong");
   chk_rx_sof_seen: assert property (
      rx_sym_valid && rx_sym == `NFC_SYM_SSD1 && s_q.rx_st == nfc_pkg::RX_IDLE
      ##1 rx_sym_valid && rx_sym == `NFC_SYM_SSD2 |=> rx_out.sof && rx_out.dv)
      else $error("start pair not flagged as frame start");
   chk_rx_eof_seen: assert property (
      rx_sym_valid && s_q.rx_st == nfc_pkg::RX_GOT_T && rx_sym == `NFC_SYM_ESD2
      |=> rx_out.eof && s_q.rx_st == nfc_pkg::RX_IDLE)
      else $error("end pair not flagged as frame end");
   chk_rx_err_flag: assert property (
      rx_sym_valid && s_q.rx_st == nfc_pkg::RX_FRAME
      && (dec.cls == nfc_pkg::CLS_INVALID || dec.cls == nfc_pkg::CLS_TXERR)
      |=> rx_out.er ##1 !rx_out.er || $past(rx_sym_valid))
      else $error("error symbol in frame not flagged");
   chk_rx_invalid_cls: assert property (
      rx_sym_valid && dec.cls == nfc_pkg::CLS_INVALID |=> rx_class == nfc_pkg::CLS_INVALID)
      else $error("undefined symbol not classed invalid");

   cov_tx_frame: cover property (
      s_q.tx_st == nfc_pkg::TX_DATA ##1 s_q.tx_st == nfc_pkg::TX_ESD2);
   cov_rx_frame: cover property (rx_out.sof ##[1:40] rx_out.eof);
   cov_rx_error: cover property (rx_out.er && rx_out.dv);
   cov_tx_stall: cover property (sym_valid && !sym_ready && !buf_rdy);
endmodule

// ===== hw/nfc_fifo.sv
// Small FIFO with valid/ready on both sides.
// Assumes one clock; in_ready low stalls the writer.
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_fifo #(
   parameter int W = 5,
   parameter int DEPTH = 2
) (
   input wire logic clock,          // Clock
   input wire logic rst,            // Async reset, high
   input wire logic in_valid,       // Write request
   output logic in_ready,           // Room for a word
   input wire logic [W-1:0] in_data, // Write data
   output logic out_valid,          // Word available
   input wire logic out_ready,      // Reader takes word
   output logic [W-1:0] out_data    // Oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [CW-1:0] cnt;
   } nfc_fifo_st_t;
   nfc_fifo_st_t s_q, s_d;
   logic push, pop;

   assign in_ready = (s_q.cnt != CW'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data = s_q.mem[s_q.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : AW'(s_q.wr + 1'b1);
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : AW'(s_q.rd + 1'b1);
      end
      if (push && !pop) begin
         s_d.cnt = CW'(s_q.cnt + 1'b1);
      end else if (pop && !push) begin
         s_d.cnt = CW'(s_q.cnt - 1'b1);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ===== tb/nfc_line_model.sv
// Line side model: sinks transmit symbols and can stall the codec.
// Assumes the codec clock and the valid/ready rule of its buffer.
`timescale 1ns/1ps
module nfc_line_model (
   input wire logic clock,          // Clock
   input wire logic rst,            // Async reset, high
   input wire logic stall,          // Hold ready low
   input wire logic [4:0] sym,      // Symbol offered
   input wire logic sym_valid,      // Symbol present
   output logic sym_ready           // Symbol taken
);
   logic [4:0] got[$];
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sym_ready <= 1'b0;
      end else begin
         sym_ready <= !stall;
         if (sym_valid && sym_ready) begin
            got.push_back(sym);
         end
      end
   end
endmodule

// ===== tb/tb.sv
// Testbench of the nibble to symbol codec.
// Assumes nfc_pkg compiled first and the line model beside it.
`timescale 1ns/1ps
module tb;
   logic clock, rst, sym_valid, sym_ready, tx_ready, rx_sym_valid, stall, saw_full;
   logic [4:0] sym_out, rx_sym;
   nfc_pkg::nfc_tx_nib_t tx_in;
   nfc_pkg::nfc_rx_nib_t rx_out;
   nfc_pkg::nfc_cls_t rx_class;
   int num_errors, total_checks;
   logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   logic [4:0] bad[11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c,
      5'h10, 5'h19, 5'h04};
   nfc_codec u_dut (.clock(clock), .rst(rst), .tx_in(tx_in), .tx_ready(tx_ready),
      .sym_out(sym_out), .sym_valid(sym_valid), .sym_ready(sym_ready), .rx_sym(rx_sym),
      .rx_sym_valid(rx_sym_valid), .rx_out(rx_out), .rx_class(rx_class));
   nfc_line_model u_line (.clock(clock), .rst(rst), .stall(stall), .sym(sym_out),
      .sym_valid(sym_valid), .sym_ready(sym_ready));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(negedge clock) begin
      if (tx_ready === 1'b0) saw_full = 1'b1;
   end
   task fail(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task cmp_sym(input logic [4:0] g, input logic [4:0] e);
      total_checks++;
      if (g !== e) fail($sformatf("symbol %h, want %h", g, e));
   endtask
   task cmp_rx(input nfc_pkg::nfc_rx_nib_t g, input logic [7:0] e);
      total_checks++;
      if (g !== e) fail($sformatf("rx nibble %h, want %h", g, e));
   endtask
   task cmp_cls(input nfc_pkg::nfc_cls_t g, input nfc_pkg::nfc_cls_t e);
      total_checks++;
      if (g !== e) fail($sformatf("class %0d, want %0d", g, e));
   endtask
   task cmp_bit(input logic g, input logic e);
      total_checks++;
      if (g !== e) fail($sformatf("flag %b, want %b", g, e));
   endtask
   task stop_test;
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Holds a nibble until the codec takes it
   task put(input nfc_pkg::nfc_tx_nib_t v);
      int n;
      tx_in <= v;
      n = 0;
      @(negedge clock);
      while (tx_ready !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      if (n == 50) fail("transmit nibble never taken");
      @(posedge clock);
   endtask
   // One symbol, then a gap cycle with a changed bus
   task rx(input logic [4:0] s, input logic [7:0] e);
      nfc_pkg::nfc_rx_nib_t g;
      rx_sym <= s;
      rx_sym_valid <= 1'b1;
      @(posedge clock);
      rx_sym <= ~s;
      rx_sym_valid <= 1'b0;
      @(negedge clock);
      g = rx_out;
      if (e[7] !== 1'b1) g.nib = e[3:0];
      cmp_rx(g, e);
      @(posedge clock);
   endtask
   task test_idle;
      repeat (4) @(posedge clock);
      cmp_sym(u_line.got[$], 5'h1f);
      cmp_cls(rx_class, nfc_pkg::CLS_IDLE);
      $display("test_idle done");
   endtask
   task test_tx_frame;
      logic [4:0] exp[$];
      u_line.got.delete();
      saw_full = 1'b0;
      exp = '{5'h18, 5'h11};
      fork
         begin
            repeat (6) @(posedge clock);
            stall <= 1'b1;
            repeat (6) @(posedge clock);
            stall <= 1'b0;
         end
         begin
            put('{1'b1, 1'b0, 4'h5});
            put('{1'b1, 1'b0, 4'h5});
            for (int n = 0; n < 16; n++) begin
               put('{1'b1, n == 7, n[3:0]});
               exp.push_back(n == 7 ? 5'h04 : enc[n]);
            end
            put('{1'b0, 1'b0, 4'h0});
         end
      join
      exp = {exp, 5'h0d, 5'h07, 5'h1f};
      repeat (10) @(posedge clock);
      while (u_line.got.size() > 0 && u_line.got[0] === 5'h1f) void'(u_line.got.pop_front());
      cmp_bit(saw_full, 1'b1);
      foreach (exp[k]) cmp_sym(u_line.got[k], exp[k]);
      $display("test_tx_frame done");
   endtask
   task test_rx_frame;
      rx(5'h18, 8'h00);
      cmp_cls(rx_class, nfc_pkg::CLS_SSD1);
      rx(5'h11, 8'ha5);
      for (int n = 0; n < 16; n++) rx(enc[n], {4'h8, n[3:0]});
      rx(5'h0d, 8'h00);
      rx(5'h07, 8'h10);
      $display("test_rx_frame done");
   endtask
   task test_rx_errors;
      rx(5'h18, 8'h00);
      rx(5'h11, 8'ha5);
      foreach (bad[i]) rx(bad[i], 8'hc0);
      rx(5'h1f, 8'h40);
      rx(5'h19, 8'h00);
      cmp_cls(rx_class, nfc_pkg::CLS_INVALID);
      $display("test_rx_errors done");
   endtask
   // Two symbols on consecutive cycles, then a gap cycle
   task rx_pair(input logic [4:0] s1, input logic [4:0] s2, input logic [7:0] e1,
      input logic [7:0] e2);
      rx_sym <= s1;
      rx_sym_valid <= 1'b1;
      @(posedge clock);
      rx_sym <= s2;
      @(negedge clock);
      cmp_rx(rx_out, e1);
      @(posedge clock);
      rx_sym <= ~s2;
      rx_sym_valid <= 1'b0;
      @(negedge clock);
      cmp_rx(rx_out, e2);
      @(posedge clock);
   endtask
   task test_rx_b2b;
      rx_pair(5'h18, 5'h11, 8'h00, 8'ha5);
      @(negedge clock);
      cmp_rx(rx_out, 8'h00);
      @(posedge clock);
      rx_pair(5'h18, 5'h11, 8'hc0, 8'hc0);
      rx_pair(5'h07, 5'h0d, 8'hc0, 8'h00);
      rx_pair(5'h16, 5'h18, 8'h40, 8'h00);
      rx_pair(5'h16, 5'h11, 8'h00, 8'h00);
      cmp_cls(rx_class, nfc_pkg::CLS_SSD2);
      $display("test_rx_b2b done");
   endtask
   initial begin
      #(40 * 3000);
      fail("watchdog expired");
      stop_test;
   end
   initial begin
      rst = 1'b1;
      tx_in = '0;
      rx_sym = 5'h00;
      rx_sym_valid = 1'b0;
      stall = 1'b0;
      saw_full = 1'b0;
      num_errors = 0;
      total_checks = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      test_idle;
      test_tx_frame;
      test_rx_frame;
      test_rx_errors;
      test_rx_b2b;
      stop_test;
   end
endmodule
